// file: dv/ext_clk_src.sv
// Pin clock model standing in for the external count source.
// Assumes the bench pulses start for one cycle; half is two or more.
module ext_clk_src (
  input wire logic clk, // System clock
  input wire logic start, // Begin a burst
  input wire logic [7:0] edges, // Pin changes in the burst
  input wire logic [3:0] half, // Clocks per level
  output logic pin // Timer count pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int left = 0;
  int cnt = 0;
  initial pin = 1'b0;
  // Level holds between bursts: this clock stands still outside them
  always @(posedge clk) begin
    if (start) begin
      left <= edges;
      cnt <= 0;
    end else if (left > 0) begin
      if (cnt + 1 >= half) begin
        pin <= ~pin;
        left <= left - 1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// file: dv/tb_prescaled_overflow_timer16.sv
// Self-checking bench for the prescaled overflow timer.
// Assumes design, package and pin clock model are compiled first.
`include "timer16_params.svh"
module tb_prescaled_overflow_timer16;
  timeunit 1ns;
  timeprecision 1ns;
  import timer16_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  apb_addr_t paddr = 8'h00;
  apb_word_t pwdata = 32'h0;
  apb_word_t prdata;
  logic pready;
  logic pslverr;
  logic ovf_irq;
  logic ext_irq_event;
  logic ext_pin;
  logic irq_pin = 1'b0;
  logic vec_ack = 1'b0;
  logic go = 1'b0;
  logic [7:0] n_edges = 8'h00;
  int mismatches = 0;
  int num_checks = 0;
  apb_word_t rd;
  logic err;
  always #20 clk = ~clk;
  prescaled_overflow_timer16 dut (.CLK(clk), .RESETN(resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_CLOCK_PIN(ext_pin),
    .EXT_IRQ_PIN(irq_pin), .IRQ_VECTOR_ACK(vec_ack), .OVF_IRQ(ovf_irq),
    .EXT_IRQ_EVENT(ext_irq_event));
  ext_clk_src src (.clk(clk), .start(go), .edges(n_edges), .half(4'h4), .pin(ext_pin));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string w);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic write16(input logic [15:0] v);
    apb(1'b1, `IDX_COUNT_LOW, v[7:0]);
    apb(1'b1, `IDX_COUNT_HIGH, v[15:8]);
  endtask
  task automatic read16(output logic [15:0] v);
    logic [7:0] lo;
    apb(1'b0, `IDX_COUNT_LOW, 8'h00);
    lo = rd[7:0];
    apb(1'b0, `IDX_COUNT_HIGH, 8'h00);
    v = {rd[7:0], lo};
    apb(1'b0, `IDX_COUNT_LOW, 8'h00);
    if (rd[7:0] < lo) begin
      lo = rd[7:0];
      apb(1'b0, `IDX_COUNT_HIGH, 8'h00);
      v = {rd[7:0], lo};
    end
  endtask
  task automatic pin_burst(input logic [7:0] n, input logic [7:0] exp);
    @(posedge clk);
    n_edges <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    // Margin covers the synchroniser delay after the last edge
    repeat (n * 4 + 12) @(posedge clk);
    apb(1'b0, `IDX_COUNT_LOW, 8'h00);
    check(rd, {24'h0, exp}, "pin count");
  endtask
  task automatic irq_edge(input logic lvl, input int exp);
    int n = 0;
    @(posedge clk);
    irq_pin <= lvl;
    repeat (10) begin
      @(posedge clk);
      if (ext_irq_event === 1'b1) n++;
    end
    check(n, exp, "irq pin events");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'b0, `IDX_TIMER_CONFIG, 8'h00);
    check(rd, 32'h0, "config reset");
    apb(1'b1, `IDX_TIMER_CONFIG, 8'hFF);
    apb(1'b0, `IDX_TIMER_CONFIG, 8'h00);
    check(rd, 32'hFE, "config bit0");
    apb(1'b0, 6'h0F, 8'h00);
    check({31'h0, err}, 32'h1, "unmapped");
  endtask
  task automatic t_ovf();
    int n = 0;
    logic [15:0] v;
    apb(1'b1, `IDX_TIMER_CONFIG, 8'h20);
    apb(1'b1, `IDX_INT_STATUS, 8'h00);
    write16(16'hFEF0);
    do begin
      apb(1'b0, `IDX_INT_STATUS, 8'h00);
      n++;
    end while (rd[`BIT_OVF_FLAG] !== 1'b1 && n < 500);
    check({31'h0, rd[`BIT_OVF_FLAG]}, 32'h1, "overflow flag");
    check({31'h0, ovf_irq}, 32'h0, "masked irq");
    read16(v);
    check({24'h0, v[15:8]}, 32'h0, "wrapped high");
    apb(1'b1, `IDX_INT_STATUS, 8'h01);
    @(posedge clk);
    check({31'h0, ovf_irq}, 32'h1, "enabled irq");
    vec_ack <= 1'b1;
    @(posedge clk);
    vec_ack <= 1'b0;
    apb(1'b0, `IDX_INT_STATUS, 8'h00);
    check({31'h0, rd[`BIT_OVF_FLAG]}, 32'h0, "flag after ack");
  endtask
  task automatic t_prescale();
    int k;
    logic ok;
    for (int c = 0; c < 10; c++) begin
      k = (c == 9) ? 8 : c;
      apb(1'b1, `IDX_TIMER_CONFIG, 8'h20 | 8'((c == 9 ? 15 : c) << 1));
      write16(16'h0000);
      repeat (32 << k) @(posedge clk);
      apb(1'b0, `IDX_COUNT_LOW, 8'h00);
      ok = rd[7:0] >= 8'h07 && rd[7:0] <= 8'h09;
      check({31'h0, ok}, 32'h1, "prescaled ticks");
    end
  endtask
  task automatic t_ext();
    apb(1'b1, `IDX_TIMER_CONFIG, 8'h40);
    apb(1'b1, `IDX_INT_STATUS, 8'h20);
    write16(16'h0000);
    pin_burst(8'h01, 8'h01);
    apb(1'b0, `IDX_INT_STATUS, 8'h00);
    check({31'h0, rd[`BIT_EXT_CLK_FLAG]}, 32'h1, "edge flag");
    pin_burst(8'h01, 8'h01);
    apb(1'b1, `IDX_TIMER_CONFIG, 8'h00);
    pin_burst(8'h02, 8'h02);
    apb(1'b1, `IDX_TIMER_CONFIG, 8'h02);
    write16(16'h0000);
    pin_burst(8'h08, 8'h02);
  endtask
  task automatic t_irqpin();
    apb(1'b1, `IDX_TIMER_CONFIG, 8'h80);
    irq_edge(1'b1, 1);
    irq_edge(1'b0, 0);
    apb(1'b1, `IDX_TIMER_CONFIG, 8'h00);
    irq_edge(1'b1, 0);
    irq_edge(1'b0, 1);
    apb(1'b0, `IDX_INT_STATUS, 8'h00);
    check({31'h0, rd[`BIT_EXT_IRQ_FLAG]}, 32'h1, "irq pin flag");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_ovf();
    t_prescale();
    t_ext();
    t_irqpin();
    report_and_stop();
  end
endmodule

// file: hw/ext_edge_sync.sv
// Pin synchroniser with a selectable edge detector.
// Assumes an asynchronous pin and the single system clock.
module ext_edge_sync (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic pin, // Raw pin level
  input wire logic rise_sel, // 1 rising, 0 falling
  output logic edge_pulse // One-cycle edge event
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  wire rise_w = sync_r & ~last_r;
  wire fall_w = ~sync_r & last_r;

  // Only sync_r reads meta_r
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign edge_pulse = rise_sel ? rise_w : fall_w;
endmodule

// file: hw/prescaled_overflow_timer16.sv
// 16-bit overflow timer with 8-bit prescaler and APB register slave.
// Assumes CLK is the oscillator phase clock; four phases form one
// instruction cycle. Pins are asynchronous and synchronised here.

module prescaled_overflow_timer16 (
  input wire logic CLK, // Phase clock
  input wire logic RESETN, // Async reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB write
  input wire timer16_pkg::apb_addr_t PADDR, // APB byte address
  input wire timer16_pkg::apb_word_t PWDATA, // APB write data
  output timer16_pkg::apb_word_t PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic EXT_CLOCK_PIN, // External count clock
  input wire logic EXT_IRQ_PIN, // External interrupt pin
  input wire logic IRQ_VECTOR_ACK, // Core vectors to timer service
  output logic OVF_IRQ, // Overflow interrupt request
  output logic EXT_IRQ_EVENT // Selected interrupt pin edge
);
  import timer16_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] config_r;
  logic [7:0] status_r;
  logic [7:0] lo_r;
  logic [7:0] hi_r;
  logic [7:0] ps_r;
  logic [1:0] phase_r;
  logic pend_r;
  logic inhib_lo_r;
  logic inhib_hi_r;
  logic [7:0] lo_nxt;
  logic [7:0] hi_nxt;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire [5:0] idx_w = PADDR[7:2];
  wire aligned_w = (PADDR[1:0] == 2'h0);
  wire sel_cfg_w = aligned_w && (idx_w == `IDX_TIMER_CONFIG);
  wire sel_sts_w = aligned_w && (idx_w == `IDX_INT_STATUS);
  wire sel_lo_w = aligned_w && (idx_w == `IDX_COUNT_LOW);
  wire sel_hi_w = aligned_w && (idx_w == `IDX_COUNT_HIGH);
  wire mapped_w = sel_cfg_w | sel_sts_w | sel_lo_w | sel_hi_w;
  wire access_w = PSEL && PENABLE;
  wire wr_w = access_w && PWRITE;
  wire wr_cfg_w = wr_w && sel_cfg_w;
  wire wr_sts_w = wr_w && sel_sts_w;
  wire wr_lo_w = wr_w && sel_lo_w;
  wire wr_hi_w = wr_w && sel_hi_w;
  wire [7:0] wdata_w = PWDATA[7:0];

  // Zero-wait slave; unmapped or misaligned access reports an error
  assign PREADY = 1'b1;
  assign PSLVERR = access_w && !mapped_w;
  wire [7:0] rd_byte_w = sel_cfg_w ? config_r :
                         sel_sts_w ? status_r :
                         sel_lo_w ? lo_r :
                         sel_hi_w ? hi_r : 8'h00;
  assign PRDATA = {24'h000000, rd_byte_w};

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  wire clk_src_w = config_r[`BIT_CLK_SOURCE];
  wire clk_edge_sel = config_r[`BIT_CLK_EDGE];
  wire ext_irq_edge_sel = config_r[`BIT_EXT_IRQ_EDGE];
  wire [3:0] prescale_code = config_r[`PRESCALE_MSB:`PRESCALE_LSB];
  wire overflow_irq_en = status_r[`BIT_OVF_IRQ_EN];
  wire overflow_flag = status_r[`BIT_OVF_FLAG];
  wire ext_clk_edge_flag = status_r[`BIT_EXT_CLK_FLAG];
  wire ext_irq_flag = status_r[`BIT_EXT_IRQ_FLAG];

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic ext_clk_evt;
  ext_edge_sync u_clk_sync (
    .clk(CLK),
    .resetn(RESETN),
    .pin(EXT_CLOCK_PIN),
    .rise_sel(clk_edge_sel),
    .edge_pulse(ext_clk_evt)
  );

  ext_edge_sync u_irq_sync (
    .clk(CLK),
    .resetn(RESETN),
    .pin(EXT_IRQ_PIN),
    .rise_sel(ext_irq_edge_sel),
    .edge_pulse(EXT_IRQ_EVENT)
  );

  // ----------------------------------------
  // Phase divider and prescaler
  // ----------------------------------------
  wire cyc_en_w = (phase_r == 2'h3);
  // Two sample points per instruction cycle
  wire sample_en_w = phase_r[0];
  wire ext_mode_w = (clk_src_t'(clk_src_w) == SRC_EXT);
  wire src_evt_w = ext_mode_w ? ext_clk_evt : cyc_en_w;
  wire [7:0] ps_mask_w = prescale_code[3] ? 8'hFF : ~(8'hFF << prescale_code[2:0]);
  wire ps_done_w = src_evt_w && ((ps_r & ps_mask_w) == ps_mask_w);
  wire cnt_wr_w = wr_lo_w | wr_hi_w;

  // Pin passes the two-flop synchroniser before the prescaler, so pin
  // edges must stay slower than CLK/4 even with a prescale in use.
  wire tick_w = ext_mode_w ? (sample_en_w && pend_r) : ps_done_w;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_r <= 2'h0;
      ps_r <= `PRESCALE_RESET;
      pend_r <= 1'b0;
    end else begin
      phase_r <= phase_r + 2'h1;
      ps_r <= cnt_wr_w ? `PRESCALE_RESET : (src_evt_w ? ps_r + 8'h01 : ps_r);
      pend_r <= ext_mode_w && !cnt_wr_w && (ps_done_w || (pend_r && !sample_en_w));
    end
  end

  // ----------------------------------------
  // Counter bytes
  // ----------------------------------------
  wire inc_lo_w = tick_w && !wr_lo_w && !inhib_lo_r;
  wire carry_w = inc_lo_w && (lo_r == 8'hFF);
  wire inc_hi_w = carry_w && !wr_hi_w && !inhib_hi_r;
  wire wrap_w = inc_hi_w && (hi_r == 8'hFF);

  always_comb begin
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    if (wr_lo_w) begin
      lo_nxt = wdata_w;
    end else if (inc_lo_w) begin
      lo_nxt = lo_r + 8'h01;
    end
    if (wr_hi_w) begin
      hi_nxt = wdata_w;
    end else if (inc_hi_w) begin
      hi_nxt = hi_r + 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      lo_r <= `COUNT_BYTE_RESET;
      hi_r <= `COUNT_BYTE_RESET;
      inhib_lo_r <= 1'b0;
      inhib_hi_r <= 1'b0;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      inhib_lo_r <= wr_lo_w;
      inhib_hi_r <= wr_hi_w;
    end
  end

  // ----------------------------------------
  // Config and status
  // ----------------------------------------
  // Flags: hardware set wins over a write-one clear or vector clear
  wire ovf_set_w = wrap_w;
  wire ovf_clr_w = IRQ_VECTOR_ACK || (wr_sts_w && wdata_w[`BIT_OVF_FLAG]);
  wire eck_set_w = ext_mode_w && ext_clk_evt;
  wire eck_clr_w = wr_sts_w && wdata_w[`BIT_EXT_CLK_FLAG];
  wire eir_clr_w = wr_sts_w && wdata_w[`BIT_EXT_IRQ_FLAG];
  wire en_nxt_w = wr_sts_w ? wdata_w[`BIT_OVF_IRQ_EN] : overflow_irq_en;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      config_r <= `CONFIG_RESET;
      status_r <= `STATUS_RESET;
    end else begin
      if (wr_cfg_w) begin
        config_r <= wdata_w & `CONFIG_WR_MASK;
      end
      status_r <= {1'b0,
                   EXT_IRQ_EVENT | (ext_irq_flag & ~eir_clr_w),
                   eck_set_w | (ext_clk_edge_flag & ~eck_clr_w),
                   ovf_set_w | (overflow_flag & ~ovf_clr_w),
                   3'h0, en_nxt_w};
    end
  end

  assign OVF_IRQ = overflow_flag && overflow_irq_en;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  wire [15:0] count_w = {hi_r, lo_r};

  wrap_zero_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    wrap_w && !cnt_wr_w |=> count_w == 16'h0000)
    else $error("count did not wrap to zero");

  ovf_flag_set_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    $past(count_w) == 16'hFFFF && count_w == 16'h0000 && !$past(cnt_wr_w)
      |-> overflow_flag)
    else $error("wrap did not set overflow flag");

  irq_mask_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    ovf_set_w |=> overflow_flag && (OVF_IRQ == overflow_irq_en))
    else $error("overflow request not gated by enable");

  vector_clear_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    IRQ_VECTOR_ACK && !wrap_w |=> !overflow_flag && !OVF_IRQ)
    else $error("vector acknowledge left flag set");

  internal_rate_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !ext_mode_w && tick_w |-> cyc_en_w ##1 !tick_w [*3])
    else $error("internal tick off instruction cycle");

  ext_flag_set_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    ext_mode_w && ext_clk_evt |=> ext_clk_edge_flag)
    else $error("pin edge did not set flag");

  // A pending tick waits for the next odd phase: one or two cycles
  ext_latency_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    ext_mode_w && ext_clk_evt && prescale_code == 4'h0 && !cnt_wr_w
      ##1 (ext_mode_w && !cnt_wr_w) [*2] |-> tick_w || $past(tick_w))
    else $error("pin edge not counted in time");

  ext_tick_sampled_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    ext_mode_w && tick_w |-> sample_en_w && $past(ps_done_w || pend_r))
    else $error("pin tick off sample point");

  prescale_clear_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    cnt_wr_w |=> ps_r == 8'h00)
    else $error("count write left prescaler");

  div_256_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !ext_mode_w && tick_w && prescale_code[3] |-> ps_r == 8'hFF)
    else $error("top prescale code not dividing by 256");

  low_inhibit_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    wr_lo_w ##1 !wr_lo_w |-> lo_r == $past(wdata_w) ##1 lo_r == $past(lo_r))
    else $error("low byte advanced after write");

  high_inhibit_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    wr_hi_w ##1 !wr_hi_w |-> hi_r == $past(wdata_w) ##1 hi_r == $past(hi_r))
    else $error("high byte advanced after write");

  high_carry_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    carry_w && !wr_hi_w && !inhib_hi_r |=> hi_r == $past(hi_r) + 8'h01)
    else $error("high byte missed carry");

  cfg_bit0_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    access_w && !PWRITE && sel_cfg_w |-> PRDATA[0] == 1'b0)
    else $error("config bit zero not zero");

  ext_irq_flag_a: assert property (
    @(posedge CLK) disable iff (!RESETN)
    EXT_IRQ_EVENT |=> ext_irq_flag)
    else $error("pin interrupt edge left flag clear");

  cover_wrap_c: cover property (@(posedge CLK) disable iff (!RESETN) wrap_w);
  cover_ext_tick_c: cover property (
    @(posedge CLK) disable iff (!RESETN) ext_mode_w && tick_w);
  cover_pair_wr_c: cover property (
    @(posedge CLK) disable iff (!RESETN) wr_lo_w ##1 wr_hi_w);
  cover_ack_c: cover property (
    @(posedge CLK) disable iff (!RESETN) OVF_IRQ ##1 IRQ_VECTOR_ACK);
  cover_div256_c: cover property (
    @(posedge CLK) disable iff (!RESETN) prescale_code[3] && tick_w);
endmodule

// file: pkg/timer16_params.svh
// Offsets, field positions, reset values and timing counts of the timer.
// Assumes inclusion by bare name from the package and the bench.
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_TIMER_CONFIG 6'h05
`define IDX_INT_STATUS 6'h07
`define IDX_COUNT_LOW 6'h0B
`define IDX_COUNT_HIGH 6'h0C

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define BIT_EXT_IRQ_EDGE 7
`define BIT_CLK_EDGE 6
`define BIT_CLK_SOURCE 5
`define PRESCALE_MSB 4
`define PRESCALE_LSB 1
`define CONFIG_WR_MASK 8'hFE

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define BIT_OVF_IRQ_EN 0
`define BIT_OVF_FLAG 4
`define BIT_EXT_CLK_FLAG 5
`define BIT_EXT_IRQ_FLAG 6

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CONFIG_RESET 8'h00
`define STATUS_RESET 8'h00
`define COUNT_BYTE_RESET 8'h00
`define PRESCALE_RESET 8'h00
`define CLK_PERIOD_NS 40
`define TOSC_PER_TCY 4
`define EXT_DELAY_MIN_TOSC 3
`define EXT_DELAY_MAX_TOSC 7

`endif

// file: pkg/timer16_pkg.sv
// Types shared by the timer and its bus slave.
// Assumes the params header sits beside it on the include path.
package timer16_pkg;
  `include "timer16_params.svh"

  typedef logic [31:0] apb_word_t;
  typedef logic [7:0] apb_addr_t;

  typedef enum logic {
    SRC_EXT = 1'b0,
    SRC_INT = 1'b1
  } clk_src_t;
endpackage
